/* src/adcm_monitor.sv */
// Converter digital comparator monitor with AXI4-Lite register access
// ----------------------------------------
// ----------------------------------------
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module adcm_monitor #(
	parameter int RES_W = 12
) (
	// Clock and reset
	input  wire logic             MCLK_IN,
	input  wire logic             ARST_N_IN,
	// Converter result stream
	input  wire logic             RES_VALID_IN,
	input  wire logic [15:0]      RES_DATA_IN,
	input  wire logic [5:0]       RES_AIN_IN,
	input  wire logic             CVD_MODE_IN,
	input  wire logic             FRACTION_FORMAT_IN,
	input  wire logic [RES_W-1:0] CVD_POS_IN,
	input  wire logic [RES_W-1:0] CVD_NEG_IN,
	// AXI4-Lite write address and data
	input  wire logic             AWVALID_IN,
	output logic                  AWREADY_OUT,
	input  wire logic [3:0]       AWADDR_IN,
	input  wire logic             WVALID_IN,
	output logic                  WREADY_OUT,
	input  wire logic [31:0]      WDATA_IN,
	input  wire logic [3:0]       WSTRB_IN,
	// AXI4-Lite write response
	output logic                  BVALID_OUT,
	input  wire logic             BREADY_IN,
	output logic [1:0]            BRESP_OUT,
	// AXI4-Lite read
	input  wire logic             ARVALID_IN,
	output logic                  ARREADY_OUT,
	input  wire logic [3:0]       ARADDR_IN,
	output logic                  RVALID_OUT,
	input  wire logic             RREADY_IN,
	output logic [31:0]           RDATA_OUT,
	output logic [1:0]            RRESP_OUT,
	// Interrupt
	output logic                  IRQ_OUT
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0]  ctrl_q;
	logic        flag_q;
	logic [5:0]  ident_q;
	logic [15:0] diff_q;
	logic [31:0] limits_q;
	logic [7:0]  stat_q;
	logic [7:0]  mask_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	logic        hit;
	logic [5:0]  hit_ain;
	logic [15:0] hit_diff;
	logic        hit_cvd;

	logic        wr_take;
	logic        rd_take;
	logic [3:0]  wr_addr;
	logic [3:0] rd_addr;
	logic        rd_clr;
	logic        irq_evt;
	logic        cmp_enable;
	logic        cmp_irq_enable;
	logic [31:0] ctrl_view;

	// Word aligned address, low two bits are ignored
	function automatic logic [3:0] word_addr(input logic [3:0] a);
		word_addr = {a[3:2], 2'b00};
	endfunction

	// Byte lane merge for a write
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	// ----------------------------------------
	// Field aliases
	// ----------------------------------------
	assign cmp_enable     = ctrl_q[adcm_pkg::BIT_ENABLE];
	assign cmp_irq_enable = ctrl_q[adcm_pkg::BIT_IRQEN];

	assign ctrl_view = {diff_q, 2'b00, ident_q, ctrl_q[7:6], flag_q, ctrl_q[4:0]};

	// ----------------------------------------
	// Condition evaluator
	// ----------------------------------------
	// evaluation gated by enable
	adcm_cond_eval #(
		.RES_W(RES_W)
	) u_eval (
		.clk_in            (MCLK_IN),
		.rst_n_in          (ARST_N_IN),
		.sample_valid_in   (RES_VALID_IN),
		.sample_in         (RES_DATA_IN),
		.ain_in            (RES_AIN_IN),
		.cvd_mode_in       (CVD_MODE_IN),
		.fraction_format_in(FRACTION_FORMAT_IN),
		.cvd_pos_in        (CVD_POS_IN),
		.cvd_neg_in        (CVD_NEG_IN),
		.limit_low_in      (limits_q[15:0]),
		.limit_high_in     (limits_q[31:16]),
		.sel_in            (ctrl_q[4:0]),
		.cmp_enable_in     (cmp_enable),
		.hit_out           (hit),
		.ain_out           (hit_ain),
		.diff_out          (hit_diff),
		.cvd_out           (hit_cvd)
	);

	// ----------------------------------------
	// Bus handshakes
	// ----------------------------------------
	// Address and data are taken together; one write in flight
	assign wr_take     = AWVALID_IN && WVALID_IN && !bvalid_q;
	assign AWREADY_OUT = wr_take;
	assign WREADY_OUT  = wr_take;
	assign rd_take     = ARVALID_IN && !rvalid_q;
	assign ARREADY_OUT = !rvalid_q;
	assign wr_addr     = word_addr(AWADDR_IN);
	assign rd_addr     = word_addr(ARADDR_IN);

	assign rd_clr  = rd_take && (rd_addr == adcm_pkg::ADDR_CTRL);
	assign irq_evt = hit && cmp_enable && cmp_irq_enable;

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	// Flag bit is masked out; writing it has no effect
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ctrl_q <= adcm_pkg::CTRL_RST;
		end else if (wr_take && wr_addr == adcm_pkg::ADDR_CTRL && WSTRB_IN[0]) begin
			ctrl_q <= (WDATA_IN[7:0] & adcm_pkg::CTRL_WMASK)
				| (ctrl_q & ~adcm_pkg::CTRL_WMASK);
		end
	end

	// Limits register
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			limits_q <= adcm_pkg::LIMITS_RST;
		end else if (wr_take && wr_addr == adcm_pkg::ADDR_LIMITS) begin
			limits_q <= merge(limits_q, WDATA_IN, WSTRB_IN);
		end
	end

	// ----------------------------------------
	// Event flag
	// ----------------------------------------
	// disable clears, hit sets, set beats read clear
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			flag_q <= 1'b0;
		end else if (!cmp_enable) begin
			flag_q <= 1'b0;
		end else if (hit) begin
			flag_q <= 1'b1;
		end else if (rd_clr) begin
			flag_q <= 1'b0;
		end
	end

	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ident_q <= 6'h00;
		end else if (hit && cmp_enable) begin
			ident_q <= hit_ain;
		end
	end

	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			diff_q <= 16'h0000;
		end else if (irq_evt && hit_cvd) begin
			diff_q <= hit_diff;
		end
	end

	// ----------------------------------------
	// Interrupt status and mask
	// ----------------------------------------
	// Write one to clear; a new event in the same cycle wins
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			stat_q <= 8'h00;
		end else begin
			stat_q <= stat_q;
			if (wr_take && wr_addr == adcm_pkg::ADDR_IRQ_STAT && WSTRB_IN[0]) begin
				stat_q <= stat_q & ~WDATA_IN[7:0];
			end
			if (irq_evt) begin
				stat_q[adcm_pkg::IRQ_EVENT] <= 1'b1;
			end
		end
	end

	// Mask register, one enables the matching status bit
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			mask_q <= 8'h00;
		end else if (wr_take && wr_addr == adcm_pkg::ADDR_IRQ_MASK && WSTRB_IN[0]) begin
			mask_q <= WDATA_IN[7:0];
		end
	end

	// Level interrupt
	assign IRQ_OUT = |(stat_q & mask_q);

	// ----------------------------------------
	// Write response
	// ----------------------------------------
	// Every write is answered OKAY; writes to unused offsets are dropped
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			bvalid_q <= 1'b0;
			bresp_q  <= adcm_pkg::RESP_OKAY;
		end else if (wr_take) begin
			bvalid_q <= 1'b1;
			bresp_q  <= adcm_pkg::RESP_OKAY;
		end else if (BREADY_IN) begin
			bvalid_q <= 1'b0;
		end
	end

	assign BVALID_OUT = bvalid_q;
	assign BRESP_OUT  = bresp_q;

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	// Data captured at address acceptance, held until taken
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= adcm_pkg::RESP_OKAY;
		end else if (rd_take) begin
			rvalid_q <= 1'b1;
			rresp_q  <= adcm_pkg::RESP_OKAY;
			case (rd_addr)
				adcm_pkg::ADDR_CTRL: begin
					rdata_q <= ctrl_view;
				end
				adcm_pkg::ADDR_LIMITS: begin
					rdata_q <= limits_q;
				end
				adcm_pkg::ADDR_IRQ_STAT: begin
					rdata_q <= {24'h000000, stat_q};
				end
				adcm_pkg::ADDR_IRQ_MASK: begin
					rdata_q <= {24'h000000, mask_q};
				end
				default: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= adcm_pkg::RESP_SLVERR;
				end
			endcase
		end else if (RREADY_IN) begin
			rvalid_q <= 1'b0;
		end
	end

	assign RVALID_OUT = rvalid_q;
	assign RDATA_OUT  = rdata_q;
	assign RRESP_OUT  = rresp_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);

	sequence s_ctrl_read;
		ARVALID_IN && ARREADY_OUT && word_addr(ARADDR_IN) == adcm_pkg::ADDR_CTRL;
	endsequence

	sequence s_irq_event;
		hit && cmp_enable && cmp_irq_enable;
	endsequence

	a_diff_capture: assert property (
		s_irq_event ##0 hit_cvd |=> diff_q == $past(hit_diff))
		else $error("difference not captured on interrupt");

	a_diff_hold: assert property (
		!irq_evt |=> diff_q == $past(diff_q))
		else $error("difference changed without interrupt");

	a_ident_load: assert property (
		hit && cmp_enable |=> ident_q == $past(hit_ain))
		else $error("input number not captured");

	a_ident_range: assert property (
		ident_q <= adcm_pkg::IDENT_MAX)
		else $error("reserved input number reported");

	a_no_hit_off: assert property (
		!cmp_enable ##1 !cmp_enable |-> !hit)
		else $error("hit while comparator disabled");

	a_flag_disable: assert property (
		!cmp_enable |=> !flag_q)
		else $error("flag kept while disabled");

	a_irq_raise: assert property (
		s_irq_event ##0 mask_q[adcm_pkg::IRQ_EVENT] && !wr_take |=> IRQ_OUT)
		else $error("interrupt not raised for event");

	a_irq_quiet: assert property (
		!cmp_irq_enable && !stat_q[adcm_pkg::IRQ_EVENT] |=> !stat_q[adcm_pkg::IRQ_EVENT])
		else $error("status set with irq enable off");

	a_flag_set: assert property (
		hit && cmp_enable |=> flag_q)
		else $error("flag not set by hit");

	a_read_clear: assert property (
		s_ctrl_read ##0 !hit && cmp_enable |=> !flag_q)
		else $error("control read did not clear flag");

	a_bits_zero: assert property (
		s_ctrl_read |=> RVALID_OUT && RDATA_OUT[15:14] == 2'b00)
		else $error("unimplemented bits read nonzero");

	a_write_resp: assert property (
		wr_take |=> BVALID_OUT)
		else $error("write not answered");

endmodule // adcm_monitor

/* shared/adcm_pkg.sv */
// Shared constants for the converter digital comparator monitor
package adcm_pkg;

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [3:0] ADDR_CTRL     = 4'h0;
	localparam logic [3:0] ADDR_LIMITS   = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;

	// ----------------------------------------
	// Control/status field positions
	// ----------------------------------------
	localparam int DIFF_LSB   = 16;
	localparam int IDENT_LSB  = 8;
	localparam int BIT_ENABLE = 7;
	localparam int BIT_IRQEN  = 6;
	localparam int BIT_FLAG   = 5;
	localparam int BIT_BTWN   = 4;
	localparam int BIT_HH     = 3;
	localparam int BIT_HL     = 2;
	localparam int BIT_LH     = 1;
	localparam int BIT_LL     = 0;
	localparam int LIM_HI_LSB = 16;
	localparam int IRQ_EVENT  = 0;

	// ----------------------------------------
	// Masks, limits and reset values
	// ----------------------------------------
	localparam logic [7:0]  CTRL_WMASK  = 8'hDF;
	localparam logic [7:0]  CTRL_RST    = 8'h00;
	localparam logic [31:0] LIMITS_RST  = 32'h0000_0000;
	localparam logic [5:0]  IDENT_MAX   = 6'h2C;
	localparam logic [5:0]  NORMAL_MAX  = 6'h1F;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

/* src/adcm_cond_eval.sv */
// Result qualifier and condition evaluator for the comparator
`timescale 1ns/1ps
module adcm_cond_eval #(
	parameter int RES_W = 12
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	// Result and context
	input  wire logic             sample_valid_in,
	input  wire logic [15:0]      sample_in,
	input  wire logic [5:0]       ain_in,
	input  wire logic             cvd_mode_in,
	input  wire logic             fraction_format_in,
	input  wire logic [RES_W-1:0] cvd_pos_in,
	input  wire logic [RES_W-1:0] cvd_neg_in,
	// Settings
	input  wire logic [15:0]      limit_low_in,
	input  wire logic [15:0]      limit_high_in,
	input  wire logic [4:0]       sel_in,
	input  wire logic             cmp_enable_in,
	// Registered verdict
	output logic                  hit_out,
	output logic [5:0]            ain_out,
	output logic [15:0]           diff_out,
	output logic                  cvd_out
);

	// Signed difference, left aligned to Q15 when fractional
	function automatic logic [15:0] fmt_diff(input logic [RES_W-1:0] p,
		input logic [RES_W-1:0] n, input logic frac);
		logic signed [RES_W:0] d;
		d = $signed({1'b0, p}) - $signed({1'b0, n});
		if (frac) begin
			fmt_diff = {d, {(15-RES_W){1'b0}}};
		end else begin
			fmt_diff = 16'($signed(d));
		end
	endfunction

	logic       ge_lo;
	logic       lt_hi;
	logic       id_ok;
	logic [4:0] cond;

	assign id_ok = cvd_mode_in ? (ain_in <= adcm_pkg::IDENT_MAX)
		: (ain_in <= adcm_pkg::NORMAL_MAX);
	assign ge_lo = sample_in >= limit_low_in;
	assign lt_hi = sample_in < limit_high_in;
	assign cond = {ge_lo && lt_hi, !lt_hi, lt_hi, ge_lo, !ge_lo};

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hit_out  <= 1'b0;
			ain_out  <= 6'h00;
			diff_out <= 16'h0000;
			cvd_out  <= 1'b0;
		end else begin
			hit_out  <= sample_valid_in && cmp_enable_in && id_ok && |(cond & sel_in);
			ain_out  <= ain_in;
			diff_out <= fmt_diff(cvd_pos_in, cvd_neg_in, fraction_format_in);
			cvd_out  <= cvd_mode_in;
		end
	end

	a_normal_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		hit_out && !cvd_out |-> ain_out <= adcm_pkg::NORMAL_MAX)
		else $error("normal mode hit from input above 31");

endmodule // adcm_cond_eval

/* tb/adcm_conv_model.sv */
// Behavioural model of the converter result path feeding the comparator
`timescale 1ns/1ps
module adcm_conv_model #(
	parameter int RES_W = 12
) (
	// Clock and request from the bench
	input  wire logic             clk_in,
	input  wire logic             go_in,
	input  wire logic [15:0]      data_in,
	input  wire logic [5:0]       ain_in,
	input  wire logic             cvd_in,
	input  wire logic             frac_in,
	input  wire logic [RES_W-1:0] pos_in,
	input  wire logic [RES_W-1:0] neg_in,
	// Result stream toward the monitor
	output logic                  valid_out,
	output logic [15:0]           data_out,
	output logic [5:0]            ain_out,
	output logic                  cvd_out,
	output logic                  frac_out,
	output logic [RES_W-1:0]      pos_out,
	output logic [RES_W-1:0]      neg_out
);
	// Known start so the first idle cycles are not unknown
	initial begin
		valid_out = 1'b0;
		{data_out, ain_out, cvd_out, frac_out, pos_out, neg_out} = '0;
	end

	// One result per request; idle lines flip so stale data never looks valid
	always @(posedge clk_in) begin
		valid_out <= go_in;
		if (go_in) begin
			{data_out, ain_out, cvd_out, frac_out} <= {data_in, ain_in, cvd_in, frac_in};
			{pos_out, neg_out} <= {pos_in, neg_in};
		end else begin
			{data_out, ain_out, cvd_out, frac_out} <= ~{data_out, ain_out, cvd_out, frac_out};
			{pos_out, neg_out} <= ~{pos_out, neg_out};
		end
	end
endmodule // adcm_conv_model

/* tb/adcm_monitor_test.sv */
// Self-checking bench for the converter comparator monitor
`timescale 1ns/1ps
module adcm_monitor_test;
	typedef struct packed {
		logic [4:0]  sel;
		logic [15:0] data;
		logic [5:0]  ain;
		logic        capacitive_divider_mode;
		logic        frac;
		logic [11:0] pos;
		logic [11:0] neg;
		logic        hit;
	} adcm_row_s;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        mclk = 1'b0, arst_n = 1'b0, irq;
	logic        aw_valid, w_valid, b_ready, ar_valid, r_ready, go, g_cvd, g_frac;
	logic        aw_ready, w_ready, b_valid, ar_ready, r_valid;
	logic [3:0]  aw_addr, ar_addr;
	logic [31:0] w_data, r_data, rdat;
	logic [1:0]  b_resp, r_resp, rresp;
	logic [15:0] g_data, res_data, cur_diff = 16'h0000;
	logic [5:0]  g_ain, res_ain, cur_ident = 6'h00;
	logic [11:0] g_pos, g_neg, res_pos, res_neg;
	logic        res_valid, res_cvd, res_frac;
	int          bad_count = 0;
	int          n_checks = 0;
	adcm_row_s   rows [9];

	// Clock at 100 MHz
	always #5 mclk = ~mclk;

	adcm_conv_model #(.RES_W(12)) conv_u (.clk_in(mclk), .go_in(go), .data_in(g_data),
		.ain_in(g_ain), .cvd_in(g_cvd), .frac_in(g_frac), .pos_in(g_pos), .neg_in(g_neg),
		.valid_out(res_valid), .data_out(res_data), .ain_out(res_ain), .cvd_out(res_cvd),
		.frac_out(res_frac), .pos_out(res_pos), .neg_out(res_neg));

	adcm_monitor #(.RES_W(12)) dut_u (.MCLK_IN(mclk), .ARST_N_IN(arst_n),
		.RES_VALID_IN(res_valid), .RES_DATA_IN(res_data), .RES_AIN_IN(res_ain),
		.CVD_MODE_IN(res_cvd), .FRACTION_FORMAT_IN(res_frac), .CVD_POS_IN(res_pos),
		.CVD_NEG_IN(res_neg), .AWVALID_IN(aw_valid), .AWREADY_OUT(aw_ready),
		.AWADDR_IN(aw_addr), .WVALID_IN(w_valid), .WREADY_OUT(w_ready), .WDATA_IN(w_data),
		.WSTRB_IN(4'hF), .BVALID_OUT(b_valid), .BREADY_IN(b_ready), .BRESP_OUT(b_resp),
		.ARVALID_IN(ar_valid), .ARREADY_OUT(ar_ready), .ARADDR_IN(ar_addr),
		.RVALID_OUT(r_valid), .RREADY_IN(r_ready), .RDATA_OUT(r_data), .RRESP_OUT(r_resp),
		.IRQ_OUT(irq));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask

	function automatic logic sig(input int k);
		case (k)
			0: return aw_ready && w_ready;
			1: return b_valid;
			2: return ar_ready;
			default: return r_valid;
		endcase
	endfunction

	// Bounded wait for a handshake seen high at a rising edge
	task automatic wait_hi(input int k);
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (sig(k) !== 1'b1 && n < 50);
		if (sig(k) !== 1'b1) begin
			bad_count++;
			end_sim();
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		{aw_valid, w_valid, aw_addr, w_data} <= {2'b11, a, d};
		wait_hi(0);
		{aw_valid, w_valid, b_ready} <= 3'b001;
		wait_hi(1);
		chk({30'h0, b_resp}, {30'h0, adcm_pkg::RESP_OKAY});
		b_ready <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		{ar_valid, ar_addr} <= {1'b1, a};
		wait_hi(2);
		{ar_valid, r_ready} <= 2'b01;
		wait_hi(3);
		{rdat, rresp} = {r_data, r_resp};
		r_ready <= 1'b0;
	endtask

	// One result, then the fixed two-edge latency plus margin
	task automatic send(input adcm_row_s r);
		logic [15:0] d;
		@(posedge mclk);
		{go, g_data, g_ain, g_cvd, g_frac, g_pos, g_neg} <= {1'b1, r[48:1]};
		@(posedge mclk);
		go <= 1'b0;
		repeat (4) @(posedge mclk);
		d = {4'h0, r.pos} - {4'h0, r.neg};
		if (r.hit) begin
			cur_ident = r.ain;
		end
		if (r.hit && r.capacitive_divider_mode) begin
			cur_diff = r.frac ? (d << 3) : d;
		end
	endtask

	task automatic chk_ctrl(input logic [7:0] cw, input logic flag);
		rd(adcm_pkg::ADDR_CTRL);
		chk(rdat, {cur_diff, 2'b00, cur_ident, cw[7:6], flag, cw[4:0]});
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		end_sim();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{aw_valid, w_valid, b_ready, ar_valid, r_ready, go, g_cvd, g_frac} = '0;
		{aw_addr, ar_addr, w_data, g_data, g_ain, g_pos, g_neg} = '0;
		// Limits low 0x0100, high 0x0200; edge values sit on both limits
		rows[0] = {5'h10, 16'h0100, 6'd3, 2'b00, 24'h0, 1'b1};
		rows[1] = {5'h10, 16'h0200, 6'd4, 2'b00, 24'h0, 1'b0};
		rows[2] = {5'h08, 16'h0200, 6'd5, 2'b00, 24'h0, 1'b1};
		rows[3] = {5'h04, 16'h01FF, 6'd31, 2'b00, 24'h0, 1'b1};
		rows[4] = {5'h02, 16'h0100, 6'd32, 2'b00, 24'h0, 1'b0};
		rows[5] = {5'h01, 16'h00FF, 6'd44, 2'b10, 12'h005, 12'h00A, 1'b1};
		rows[6] = {5'h01, 16'h00FF, 6'd45, 2'b10, 12'h005, 12'h00A, 1'b0};
		rows[7] = {5'h02, 16'h0300, 6'd40, 2'b11, 12'hFFF, 12'h000, 1'b1};
		rows[8] = {5'h00, 16'h0150, 6'd2, 2'b00, 24'h0, 1'b0};
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		rd(adcm_pkg::ADDR_CTRL);
		chk(rdat, 32'h0);
		// Low address bits are ignored, so this reaches the control word
		rd(4'h2);
		chk({30'h0, rresp}, {30'h0, adcm_pkg::RESP_OKAY});
		chk(rdat, 32'h0);
		wr(adcm_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
		chk_ctrl(8'hDF, 1'b0);
		wr(adcm_pkg::ADDR_LIMITS, 32'h0200_0100);
		wr(adcm_pkg::ADDR_IRQ_MASK, 32'h1);
		foreach (rows[i]) begin
			wr(adcm_pkg::ADDR_CTRL, 32'h0);
			wr(adcm_pkg::ADDR_IRQ_STAT, 32'h1);
			wr(adcm_pkg::ADDR_CTRL, {24'h0, 3'b110, rows[i].sel});
			send(rows[i]);
			chk({31'h0, irq}, {31'h0, rows[i].hit});
			chk_ctrl({3'b110, rows[i].sel}, rows[i].hit);
			chk_ctrl({3'b110, rows[i].sel}, 1'b0);
		end
		// Event without interrupt enable
		wr(adcm_pkg::ADDR_CTRL, 32'h0);
		wr(adcm_pkg::ADDR_IRQ_STAT, 32'h1);
		wr(adcm_pkg::ADDR_CTRL, 32'h90);
		send({5'h10, 16'h0150, 6'd7, 2'b00, 24'h0, 1'b1});
		chk({31'h0, irq}, 32'h0);
		rd(adcm_pkg::ADDR_IRQ_STAT);
		chk(rdat, 32'h0);
		chk_ctrl(8'h90, 1'b1);
		// Masked interrupt, then unmask, then disable with the flag up
		wr(adcm_pkg::ADDR_IRQ_MASK, 32'h0);
		wr(adcm_pkg::ADDR_CTRL, 32'hD0);
		send({5'h10, 16'h0150, 6'd9, 2'b00, 24'h0, 1'b1});
		chk({31'h0, irq}, 32'h0);
		rd(adcm_pkg::ADDR_IRQ_STAT);
		chk(rdat, 32'h1);
		wr(adcm_pkg::ADDR_IRQ_MASK, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(adcm_pkg::ADDR_CTRL, 32'h50);
		chk_ctrl(8'h50, 1'b0);
		wr(adcm_pkg::ADDR_IRQ_STAT, 32'h1);
		chk({31'h0, irq}, 32'h0);
		send({5'h10, 16'h0150, 6'd10, 2'b00, 24'h0, 1'b0});
		chk_ctrl(8'h50, 1'b0);
		rd(adcm_pkg::ADDR_IRQ_STAT);
		chk(rdat, 32'h0);
		// Reset in mid-run with the flag up must clear the control, limits and mask registers
		wr(adcm_pkg::ADDR_CTRL, 32'h90);
		send({5'h10, 16'h0150, 6'd11, 2'b00, 24'h0, 1'b1});
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		cur_ident = 6'h00;
		cur_diff = 16'h0000;
		chk({31'h0, irq}, 32'h0);
		chk_ctrl(8'h00, 1'b0);
		rd(adcm_pkg::ADDR_LIMITS);
		chk(rdat, adcm_pkg::LIMITS_RST);
		rd(adcm_pkg::ADDR_IRQ_MASK);
		chk(rdat, 32'h0);
		end_sim();
	end
endmodule // adcm_monitor_test
